// ==== hdl/pcc_pkg.sv ====
`default_nettype none
package pcc_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_PWR  = 10'h010;
    localparam logic [9:0] IDX_ABL  = 10'h017;
    localparam logic [9:0] IDX_CAL  = 10'h018;
    localparam logic [9:0] IDX_DIV  = 10'h1E0;
    localparam logic [9:0] IDX_SRC  = 10'h1E1;
    localparam logic [9:0] IDX_UPD  = 10'h232;
    localparam logic [9:0] IDX_ICP  = 10'h1F0;
    localparam logic [9:0] IDX_STAT = 10'h1F1;
    localparam int         IDX_LSB  = 2;
    localparam int         IDX_W    = 10;
    // Reset values.
    localparam logic [7:0] RST_PWR  = 8'h01;
    localparam logic [7:0] RST_ABL  = 8'h00;
    localparam logic [7:0] RST_CAL  = 8'h00;
    localparam logic [7:0] RST_DIV  = 8'h02;
    localparam logic [7:0] RST_SRC  = 8'h00;
    localparam logic [7:0] RST_ICP  = 8'h00;
    // Field positions and widths.
    localparam int PWR_LSB  = 0;
    localparam int PWR_W    = 2;
    localparam int CPM_LSB  = 4;
    localparam int CPM_W    = 3;
    localparam int POL_BIT  = 7;
    localparam int ABL_W    = 2;
    localparam int DIV_W    = 3;
    localparam int ICP_W    = 3;
    localparam int BYP_BIT  = 0;
    localparam int SRC_BIT  = 1;
    localparam int CAL_BIT  = 0;
    localparam int UPD_BIT  = 0;
    localparam int STAT_CAL = 0;
    localparam int STAT_RUN = 1;
    localparam int STAT_POL = 2;
    localparam int STAT_UPD = 3;
    // Encodings.
    localparam logic [1:0] PWR_RUN      = 2'h0;
    localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
    localparam logic [2:0] CPM_HIZ      = 3'h0;
    localparam logic [2:0] CPM_UP       = 3'h1;
    localparam logic [2:0] CPM_DN       = 3'h2;
    localparam logic [2:0] CPM_NORMAL   = 3'h3;
    localparam logic [2:0] DIV_OFFSET   = 3'h2;
    localparam logic [2:0] DIV_CODE_MAX = 3'h4;
    localparam logic [2:0] DIV_RATIO_MAX = 3'h6;
    localparam logic       POL_INTERNAL = 1'b0;
    localparam int         ICP_LSB_UA   = 600;
    localparam int         ICP_MAX_UA   = 4800;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : pcc_pkg
`default_nettype wire

// ==== hdl/pcc_phase_detector.sv ====
`default_nettype none
module pcc_phase_detector
    import pcc_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ref_edge,
    input  wire logic         fb_edge,
    input  wire logic [2:0]   cp_mode,
    input  wire logic [1:0]   abl_sel,
    input  wire logic         pll_off,
    output logic              pump_up,
    output logic              pump_dn,
    output logic              pump_hiz
);
    typedef enum logic [3:0] {
        PFD_IDLE = 4'b0001,
        PFD_UP   = 4'b0010,
        PFD_DN   = 4'b0100,
        PFD_RST  = 4'b1000
    } pcc_pfd_e;

    pcc_pfd_e   state;
    pcc_pfd_e   next_state;
    logic [2:0] abl_cnt;

    // Both pumps stay on for abl_sel+1 cycles so the detector has no dead zone.
    always_comb
    begin
        next_state = state;
        case (state)
            PFD_IDLE: next_state = ref_edge ? (fb_edge ? PFD_RST : PFD_UP)
                                            : (fb_edge ? PFD_DN : PFD_IDLE);
            PFD_UP:   next_state = fb_edge ? PFD_RST : PFD_UP;
            PFD_DN:   next_state = ref_edge ? PFD_RST : PFD_DN;
            PFD_RST:  next_state = (abl_cnt >= {1'b0, abl_sel}) ? PFD_IDLE : PFD_RST;
            default:  next_state = PFD_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || pll_off || cp_mode != CPM_NORMAL)
        begin
            state   <= PFD_IDLE;
            abl_cnt <= 3'h0;
        end
        else
        begin
            state   <= next_state;
            abl_cnt <= (next_state == PFD_RST && state == PFD_RST) ? abl_cnt + 3'h1 : 3'h0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || pll_off)
        begin
            pump_up  <= 1'b0;
            pump_dn  <= 1'b0;
            pump_hiz <= 1'b1;
        end
        else
        begin
            case (cp_mode)
                CPM_UP:     {pump_up, pump_dn, pump_hiz} <= 3'b100;
                CPM_DN:     {pump_up, pump_dn, pump_hiz} <= 3'b010;
                CPM_NORMAL:
                begin
                    pump_up  <= next_state == PFD_UP || next_state == PFD_RST;
                    pump_dn  <= next_state == PFD_DN || next_state == PFD_RST;
                    pump_hiz <= 1'b0;
                end
                default:    {pump_up, pump_dn, pump_hiz} <= 3'b001;
            endcase
        end
    end

    property p_hiz_mode;
        @(posedge aclk) disable iff (!aresetn)
        cp_mode == CPM_HIZ |=> pump_hiz && !pump_up && !pump_dn;
    endproperty
    a_hiz_mode: assert property (p_hiz_mode) else $error("pump not idle in hiz mode");

    property p_ref_pumps_up;
        @(posedge aclk) disable iff (!aresetn)
        !pll_off && cp_mode == CPM_NORMAL && state == PFD_IDLE && ref_edge && !fb_edge
            |=> pump_up && !pump_dn;
    endproperty
    a_ref_pumps_up: assert property (p_ref_pumps_up) else $error("no pump up on ref lead");

    property p_abl_bound;
        @(posedge aclk) disable iff (!aresetn)
        state == PFD_RST |-> abl_cnt <= {1'b0, abl_sel};
    endproperty
    a_abl_bound: assert property (p_abl_bound) else $error("antibacklash overran");
endmodule : pcc_phase_detector
`default_nettype wire

// ==== hdl/pcc_pll_clock_path_config.sv ====
`default_nettype none
module pcc_pll_clock_path_config
    import pcc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              ref_div_pulse,
    input  wire logic              fb_div_pulse,
    output logic                   pll_power_down,
    output logic                   vco_cal_start,
    output logic [2:0]             post_div_ratio,
    output logic                   div_bypass,
    output logic                   src_internal,
    output logic                   vco_polarity_neg,
    output logic [2:0]             pump_current_setting,
    output logic                   pump_up,
    output logic                   pump_dn,
    output logic                   pump_hiz
);
    if (ADDR_W < IDX_W + IDX_LSB)
    begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    logic [7:0]       pwr_ctrl;
    logic [7:0]       abl_ctrl;
    logic [7:0]       cal_ctrl;
    logic [7:0]       div_ctrl;
    logic [7:0]       src_ctrl;
    logic [7:0]       icp_ctrl;
    logic             upd_flag;
    logic             cal_active;
    logic             cal_active_d;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0]       w_byte;
    logic             w_lane0;
    logic             wr_go;
    logic             wr_hit;
    logic             upd_wr;
    logic [IDX_W-1:0] ar_idx;
    logic [31:0]      next_rdata;
    logic             rd_hit;
    logic [2:0]       div_code;

    assign wr_go  = !awready && !wready && !bvalid;
    assign upd_wr = wr_go && w_lane0 && aw_idx == IDX_UPD && w_byte[UPD_BIT];
    assign ar_idx = araddr[IDX_LSB +: IDX_W];
    assign div_code = div_ctrl[DIV_W-1:0];

    always_comb
    begin
        wr_hit = 1'b1;
        case (aw_idx)
            IDX_PWR, IDX_ABL, IDX_CAL, IDX_DIV,
            IDX_SRC, IDX_UPD, IDX_ICP, IDX_STAT: wr_hit = 1'b1;
            default:                             wr_hit = 1'b0;
        endcase
    end

    // Write address and data are taken in either order; the write happens
    // once both are held, so the response always follows both.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            aw_idx  <= '0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                aw_idx  <= awaddr[IDX_LSB +: IDX_W];
            end
            if (wvalid && wready)
            begin
                wready  <= 1'b0;
                w_byte  <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
            if (wr_go)
            begin
                bvalid  <= 1'b1;
                bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Only byte lane 0 carries register bits; other lanes are ignored.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_ctrl <= RST_PWR;
            abl_ctrl <= RST_ABL;
            cal_ctrl <= RST_CAL;
            div_ctrl <= RST_DIV;
            src_ctrl <= RST_SRC;
            icp_ctrl <= RST_ICP;
        end
        else if (wr_go && w_lane0)
        begin
            case (aw_idx)
                IDX_PWR: pwr_ctrl <= w_byte;
                IDX_ABL: abl_ctrl <= w_byte;
                IDX_CAL: cal_ctrl <= w_byte;
                IDX_DIV: div_ctrl <= w_byte;
                IDX_SRC: src_ctrl <= w_byte;
                IDX_ICP: icp_ctrl <= w_byte;
                default: ;
            endcase
        end
    end

    // A fresh update write in the cycle the flag clears keeps it set.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            upd_flag     <= 1'b0;
            cal_active   <= 1'b0;
            cal_active_d <= 1'b0;
        end
        else
        begin
            upd_flag <= upd_wr;
            if (upd_flag)
            begin
                cal_active <= cal_ctrl[CAL_BIT];
            end
            cal_active_d <= cal_active;
        end
    end

    // Only a 0 to 1 step of the active bit starts a calibration, which is why
    // the clearing write is needed before every calibration after the first.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vco_cal_start <= 1'b0;
        end
        else
        begin
            vco_cal_start <= cal_active && !cal_active_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pll_power_down       <= RST_PWR[PWR_LSB +: PWR_W] != PWR_RUN;
            post_div_ratio       <= RST_DIV[DIV_W-1:0] + DIV_OFFSET;
            div_bypass           <= RST_SRC[BYP_BIT];
            src_internal         <= RST_SRC[SRC_BIT];
            vco_polarity_neg     <= RST_PWR[POL_BIT];
            pump_current_setting <= RST_ICP[ICP_W-1:0];
        end
        else
        begin
            pll_power_down   <= pwr_ctrl[PWR_LSB +: PWR_W] != PWR_RUN;
            // Codes above the top ratio saturate at divide by 6.
            post_div_ratio   <= (div_code > DIV_CODE_MAX) ? DIV_RATIO_MAX
                                : 3'(div_code + DIV_OFFSET);
            div_bypass       <= src_ctrl[BYP_BIT];
            src_internal     <= src_ctrl[SRC_BIT];
            vco_polarity_neg <= src_ctrl[SRC_BIT] ? POL_INTERNAL
                                : pwr_ctrl[POL_BIT];
            // Current is (setting + 1) times the 600 uA step.
            pump_current_setting <= icp_ctrl[ICP_W-1:0];
        end
    end

    pcc_phase_detector u_pfd (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ref_edge (ref_div_pulse),
        .fb_edge  (fb_div_pulse),
        .cp_mode  (pwr_ctrl[CPM_LSB +: CPM_W]),
        .abl_sel  (abl_ctrl[ABL_W-1:0]),
        .pll_off  (pll_power_down),
        .pump_up  (pump_up),
        .pump_dn  (pump_dn),
        .pump_hiz (pump_hiz)
    );

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        rd_hit     = 1'b1;
        case (ar_idx)
            IDX_PWR:  next_rdata[7:0] = pwr_ctrl;
            IDX_ABL:  next_rdata[7:0] = abl_ctrl;
            IDX_CAL:  next_rdata[7:0] = cal_ctrl;
            IDX_DIV:  next_rdata[7:0] = div_ctrl;
            IDX_SRC:  next_rdata[7:0] = src_ctrl;
            IDX_ICP:  next_rdata[7:0] = icp_ctrl;
            IDX_UPD:  next_rdata[UPD_BIT] = upd_flag;
            IDX_STAT:
            begin
                next_rdata[STAT_CAL] = cal_active;
                next_rdata[STAT_RUN] = !pll_power_down;
                next_rdata[STAT_POL] = vco_polarity_neg;
                next_rdata[STAT_UPD] = upd_flag;
            end
            default:  rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= next_rdata;
            rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    property p_power_field;
        @(posedge aclk) disable iff (!aresetn)
        ##1 pll_power_down == ($past(pwr_ctrl[PWR_LSB +: PWR_W]) != PWR_RUN);
    endproperty
    a_power_field: assert property (p_power_field) else $error("power state wrong");

    property p_cal_start;
        @(posedge aclk) disable iff (!aresetn)
        vco_cal_start |-> $past(cal_active) && !$past(cal_active, 2);
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("stray calibration start");

    property p_cal_gated;
        @(posedge aclk) disable iff (!aresetn)
        ##1 $changed(cal_active) |-> $past(upd_flag);
    endproperty
    a_cal_gated: assert property (p_cal_gated) else $error("calibration bit not gated");

    property p_upd_clears;
        @(posedge aclk) disable iff (!aresetn)
        upd_flag && !upd_wr |=> !upd_flag;
    endproperty
    a_upd_clears: assert property (p_upd_clears) else $error("update bit stuck");

    property p_ratio_range;
        @(posedge aclk) disable iff (!aresetn)
        post_div_ratio >= DIV_OFFSET && post_div_ratio <= DIV_RATIO_MAX;
    endproperty
    a_ratio_range: assert property (p_ratio_range) else $error("ratio out of range");

    property p_polarity;
        @(posedge aclk) disable iff (!aresetn)
        ##1 vco_polarity_neg == ($past(src_ctrl[SRC_BIT]) ? POL_INTERNAL
                                 : $past(pwr_ctrl[POL_BIT]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_route;
        @(posedge aclk) disable iff (!aresetn)
        ##1 div_bypass == $past(src_ctrl[BYP_BIT]) && src_internal == $past(src_ctrl[SRC_BIT]);
    endproperty
    a_route: assert property (p_route) else $error("clock routing wrong");

    property p_reset_defaults;
        @(posedge aclk)
        !aresetn |=> pwr_ctrl == RST_PWR && div_ctrl == RST_DIV && src_ctrl == RST_SRC;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset value");

    property p_icp;
        @(posedge aclk) disable iff (!aresetn)
        ##1 pump_current_setting == $past(icp_ctrl[ICP_W-1:0]);
    endproperty
    a_icp: assert property (p_icp) else $error("pump current wrong");
endmodule : pcc_pll_clock_path_config
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top
    import pcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk;
    logic        aresetn;
    logic [11:0] awaddr;
    logic [11:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [1:0]  resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ref_div_pulse, fb_div_pulse;
    logic        pll_power_down, vco_cal_start, div_bypass, src_internal;
    logic        vco_polarity_neg, pump_up, pump_dn, pump_hiz;
    logic [2:0]  post_div_ratio;
    logic [2:0]  pump_current_setting;
    int          fails = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          cal_pulses = 0;

    pcc_pll_clock_path_config dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
        .pll_power_down(pll_power_down), .vco_cal_start(vco_cal_start),
        .post_div_ratio(post_div_ratio), .div_bypass(div_bypass),
        .src_internal(src_internal), .vco_polarity_neg(vco_polarity_neg),
        .pump_current_setting(pump_current_setting), .pump_up(pump_up),
        .pump_dn(pump_dn), .pump_hiz(pump_hiz)
    );

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d.", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The whole run needs a few hundred cycles; the ceiling only catches a hung handshake.
    always @(posedge aclk)
    begin
        cycles++;
        if (vco_cal_start === 1'b1)
            cal_pulses++;
        if (cycles == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (bvalid === 1'b1)
            begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
        end
    endtask

    task automatic rdreg(input logic [9:0] idx);
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (rvalid === 1'b1)
            begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
        end
    endtask

    // Derived outputs trail the register by one edge, the pumps by two after a power change; three edges leave margin.
    task automatic wrs(input logic [9:0] idx, input logic [7:0] d);
        wr(idx, d);
        repeat (3) @(posedge aclk);
    endtask

    task automatic t_reset();
        chk("pll_power_down", 32'(pll_power_down), 32'h1);
        chk("post_div_ratio", 32'(post_div_ratio), 32'h4);
        chk("div_bypass", 32'(div_bypass), 32'h0);
        chk("src_internal", 32'(src_internal), 32'h0);
        rdreg(IDX_PWR);
        chk("pwr reg", rd, 32'(RST_PWR));
        rdreg(IDX_DIV);
        chk("div reg", rd, 32'(RST_DIV));
        rdreg(IDX_SRC);
        chk("src reg", rd, 32'(RST_SRC));
    endtask

    task automatic t_power_source();
        wrs(IDX_PWR, 8'h00);
        chk("pll_power_down", 32'(pll_power_down), 32'h0);
        wrs(IDX_PWR, 8'h01);
        chk("pll_power_down", 32'(pll_power_down), 32'h1);
        for (int c = 0; c < 8; c++)
        begin
            wrs(IDX_DIV, 8'(c));
            chk("post_div_ratio", 32'(post_div_ratio), 32'((c > 4) ? 6 : c + 2));
        end
        rdreg(IDX_DIV);
        chk("div readback", rd, 32'h7);
        chk("div rresp", 32'(resp), 32'(RESP_OKAY));
        for (int c = 0; c < 4; c++)
        begin
            wrs(IDX_SRC, 8'(c));
            chk("div_bypass", 32'(div_bypass), 32'(c & 1));
            chk("src_internal", 32'(src_internal), 32'(c >> 1));
        end
    endtask

    task automatic t_ext_source();
        wrs(IDX_SRC, 8'h01);
        wrs(IDX_PWR, 8'h01);
        chk("ext bypass power", 32'(pll_power_down), 32'h1);
        chk("ext bypass route", 32'({div_bypass, src_internal}), 32'h2);
        wrs(IDX_PWR, 8'h00);
        chk("ext synth on", 32'(pll_power_down), 32'h0);
        chk("ext source kept", 32'(src_internal), 32'h0);
        wrs(IDX_PWR, 8'h02);
        chk("power code 10", 32'(pll_power_down), 32'h1);
    endtask

    task automatic t_polarity();
        wrs(IDX_SRC, 8'h00);
        wrs(IDX_PWR, 8'h80);
        chk("polarity neg", 32'(vco_polarity_neg), 32'h1);
        wrs(IDX_PWR, 8'h00);
        chk("polarity pos", 32'(vco_polarity_neg), 32'h0);
        wrs(IDX_PWR, 8'h80);
        wrs(IDX_SRC, 8'h02);
        chk("polarity internal", 32'(vco_polarity_neg), 32'h0);
    endtask

    task automatic t_calibration();
        int p;
        p = cal_pulses;
        wrs(IDX_PWR, 8'h00);
        wrs(IDX_SRC, 8'h02);
        wrs(IDX_CAL, 8'h01);
        chk("cal before update", 32'(cal_pulses - p), 32'h0);
        wrs(IDX_UPD, 8'h01);
        repeat (3) @(posedge aclk);
        chk("cal after update", 32'(cal_pulses - p), 32'h1);
        rdreg(IDX_STAT);
        chk("update self clear", 32'(rd[STAT_UPD]), 32'h0);
        wrs(IDX_CAL, 8'h01);
        wrs(IDX_UPD, 8'h01);
        repeat (3) @(posedge aclk);
        chk("cal without clear", 32'(cal_pulses - p), 32'h1);
        wrs(IDX_CAL, 8'h00);
        wrs(IDX_UPD, 8'h01);
        wrs(IDX_CAL, 8'h01);
        wrs(IDX_UPD, 8'h01);
        repeat (3) @(posedge aclk);
        chk("cal restart", 32'(cal_pulses - p), 32'h2);
    endtask

    task automatic t_pump();
        for (int m = 0; m < 8; m++)
        begin
            wrs(IDX_PWR, {1'b0, 3'(m), 4'h0});
            chk("pump_up", 32'(pump_up), 32'(m == 1));
            chk("pump_dn", 32'(pump_dn), 32'(m == 2));
            chk("pump_hiz", 32'(pump_hiz), 32'(m == 0 || m > 3));
        end
        wrs(IDX_PWR, 8'h11);
        chk("pump_up off", 32'(pump_up), 32'h0);
        chk("pump_hiz off", 32'(pump_hiz), 32'h1);
        for (int n = 0; n < 8; n++)
        begin
            wrs(IDX_ICP, 8'(n));
            chk("pump_current_setting", 32'(pump_current_setting), 32'(n));
        end
    endtask

    task automatic t_detector(input logic [1:0] abl);
        int both;
        both = 0;
        wrs(IDX_PWR, 8'h30);
        wrs(IDX_ABL, {6'h0, abl});
        ref_div_pulse <= 1'b1;
        @(posedge aclk);
        ref_div_pulse <= 1'b0;
        @(posedge aclk);
        chk("pump_up on ref", 32'(pump_up), 32'h1);
        chk("pump_dn on ref", 32'(pump_dn), 32'h0);
        fb_div_pulse <= 1'b1;
        @(posedge aclk);
        fb_div_pulse <= 1'b0;
        repeat (12)
        begin
            @(posedge aclk);
            if (pump_up === 1'b1 && pump_dn === 1'b1)
                both++;
        end
        chk("antibacklash width", 32'(both), 32'(abl) + 32'h1);
        chk("pump_up after reset", 32'(pump_up), 32'h0);
    endtask

    task automatic t_unmapped();
        wr(10'h3FF, 8'h5A);
        chk("bresp unmapped", 32'(resp), 32'(RESP_SLVERR));
        rdreg(10'h3FF);
        chk("rresp unmapped", 32'(resp), 32'(RESP_SLVERR));
        chk("rdata unmapped", rd, 32'h0);
    endtask

    initial
    begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {ref_div_pulse, fb_div_pulse} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_power_source();
        t_ext_source();
        t_polarity();
        t_calibration();
        t_pump();
        t_detector(2'h0);
        t_detector(2'h3);
        t_unmapped();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
